// ---- core/storage_packet_pkg.sv ----
// Constants, register map and field layout for the dual-drive block framer.
// Assumes a single clock domain and an AXI4-Lite register bus with 32-bit data.
package storage_packet_pkg;
  // ==========================================================================
  // Bus and register map
  // ==========================================================================
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_START = 8'h04;
  localparam logic [ADDR_W-1:0] REG_COUNT = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_WRITTEN = 8'h10;
  localparam logic [ADDR_W-1:0] REG_REPLY = 8'h14;
  localparam logic [ADDR_W-1:0] REG_STREAM = 8'h18;
  localparam int CTRL_START = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_ERR = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] START_RESET = 32'h0;
  localparam logic [31:0] COUNT_RESET = 32'h0;
  localparam logic [3:0] STREAM_RESET = 4'h0;

  // ==========================================================================
  // Blocks and packet headers
  // ==========================================================================
  localparam int BLOCK_BYTES = 4096;
  localparam int WORD_BYTES = 4;
  localparam int BLOCK_WORDS = BLOCK_BYTES / WORD_BYTES;
  localparam int CNT_W = 11;
  localparam logic [CNT_W-1:0] BLOCK_CNT = 11'h400;
  localparam logic [9:0] PAY_LAST = 10'h3ff;
  localparam logic [1:0] REQ_HDR_LAST = 2'h3;
  localparam logic [1:0] RPL_HDR_LAST = 2'h2;
  localparam logic [1:0] RPL_PAYLOAD = 2'h3;
  localparam int DRV_LSB = 28;
  localparam int ADDR_FIELD_W = 24;
  localparam int REPLY_FLAG = 31;
  localparam logic [3:0] REQ_WRITE = 4'h1;
  localparam int RB_LSB = 16;
  localparam int RE_LSB = 12;
  localparam int RU_LSB = 12;
  localparam int RN_LSB = 16;
  localparam int FIFO_DEPTH = 16;

  typedef enum {ST_IDLE, ST_HDR, ST_PAY} frame_state_t;
endpackage : storage_packet_pkg

// ---- core/storage_packet_header_format.sv ----
// Dual-drive block framer: FIFO, request header builder, reply decoder, registers.
// Assumes one clock (aclk) and a packet switch behind the two request streams.
`timescale 1ns/1ps

// ============================================================================
// Word FIFO
// ============================================================================
module word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic aclk, // Clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [WIDTH-1:0] in_data, // Write data.
  input wire logic in_valid, // Write data valid.
  output logic in_ready, // Space available.
  output logic [WIDTH-1:0] out_data, // Head word.
  output logic out_valid, // Head word valid.
  input wire logic out_ready // Head word taken.
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] rptr_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  assign in_ready = cnt_reg != FULL;
  assign out_valid = cnt_reg != '0;
  assign out_data = mem[rptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wptr_reg] <= in_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg <= rptr_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule : word_fifo

// ============================================================================
// Framer top
// ============================================================================
module storage_packet_header_format
  import storage_packet_pkg::*;
(
  input wire logic aclk, // Root-complex user clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [ADDR_W-1:0] awaddr, // Write address.
  input wire logic awvalid, // Write address valid.
  output logic awready, // Write address ready.
  input wire logic [31:0] wdata, // Write data.
  input wire logic [3:0] wstrb, // Write byte strobes.
  input wire logic wvalid, // Write data valid.
  output logic wready, // Write data ready.
  output logic [1:0] bresp, // Write response.
  output logic bvalid, // Write response valid.
  input wire logic bready, // Write response ready.
  input wire logic [ADDR_W-1:0] araddr, // Read address.
  input wire logic arvalid, // Read address valid.
  output logic arready, // Read address ready.
  output logic [31:0] rdata, // Read data.
  output logic [1:0] rresp, // Read response.
  output logic rvalid, // Read data valid.
  input wire logic rready, // Read data ready.
  input wire logic [31:0] s_tdata, // Incoming data stream.
  input wire logic s_tvalid, // Incoming data valid.
  output logic s_tready, // Incoming data ready.
  output logic [31:0] m_tdata, // Request packet word, both drive paths.
  output logic m_tlast, // Last word of a request packet.
  output logic m0_tvalid, // Word valid for drive 0 path.
  input wire logic m0_tready, // Drive 0 path ready.
  output logic m1_tvalid, // Word valid for drive 1 path.
  input wire logic m1_tready, // Drive 1 path ready.
  input wire logic [31:0] r_tdata, // Reply packet word.
  input wire logic r_tvalid, // Reply word valid.
  output logic r_tready, // Reply word ready.
  input wire logic r_tlast, // Last reply word.
  output logic [31:0] rd_tdata, // Read-back data word.
  output logic rd_tvalid, // Read-back word valid.
  input wire logic rd_tready, // Read-back word ready.
  output logic rd_tlast // Last read-back word.
);
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // ==========================================================================
  // Register bus
  // ==========================================================================
  logic aw_full_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic w_full_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic do_write;
  logic wr_known;
  logic start_pulse;
  logic err_clear;
  logic [31:0] start_block_reg;
  logic [31:0] num_blocks_reg;
  logic [3:0] stream_reg;
  logic done_reg;
  logic err_reg;
  logic [31:0] written_reg;
  logic [11:0] rpl_bytes_reg;
  logic [3:0] rpl_err_reg;
  logic [3:0] rpl_stat_reg;
  logic [3:0] rpl_drv_reg;
  logic [7:0] rpl_tag_reg;
  logic busy;
  logic blk_end;
  logic rpl_done;
  logic rpl_bad;

  assign awready = !aw_full_reg;
  assign wready = !w_full_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = !rvalid_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wr_known = aw_addr_reg inside {REG_CTRL, REG_START, REG_COUNT, REG_STATUS, REG_STREAM};
  assign start_pulse = do_write && aw_addr_reg == REG_CTRL && w_strb_reg[0] && w_data_reg[CTRL_START];
  assign err_clear = do_write && aw_addr_reg == REG_STATUS && w_strb_reg[0] && w_data_reg[STAT_ERR];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_full_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (awvalid && !aw_full_reg) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end
      if (wvalid && !w_full_reg) begin
        w_full_reg <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      if (do_write) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Range registers are frozen while a run is under way.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_block_reg <= START_RESET;
      num_blocks_reg <= COUNT_RESET;
      stream_reg <= STREAM_RESET;
    end else if (do_write && !busy) begin
      if (aw_addr_reg == REG_START) begin
        start_block_reg <= merge(start_block_reg, w_data_reg, w_strb_reg);
      end
      if (aw_addr_reg == REG_COUNT) begin
        num_blocks_reg <= merge(num_blocks_reg, w_data_reg, w_strb_reg);
      end
      if (aw_addr_reg == REG_STREAM && w_strb_reg[0]) begin
        stream_reg <= w_data_reg[3:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else if (arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= RESP_OKAY;
      unique case (araddr)
        REG_CTRL: rdata_reg <= '0;
        REG_START: rdata_reg <= start_block_reg;
        REG_COUNT: rdata_reg <= num_blocks_reg;
        REG_STATUS: rdata_reg <= {29'h0, err_reg, done_reg, busy};
        REG_WRITTEN: rdata_reg <= written_reg;
        REG_REPLY: rdata_reg <= {rpl_drv_reg, rpl_stat_reg, rpl_err_reg, rpl_bytes_reg, rpl_tag_reg};
        REG_STREAM: rdata_reg <= {28'h0, stream_reg};
        default: begin
          rdata_reg <= '0;
          rresp_reg <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // An error report in the clearing cycle keeps the flag set.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      if (rpl_bad) begin
        err_reg <= 1'b1;
      end else if (err_clear) begin
        err_reg <= 1'b0;
      end
      if (start_pulse && !busy) begin
        done_reg <= 1'b0;
      end else if (blk_end && busy && written_reg + 1'b1 == num_blocks_reg) begin
        done_reg <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Input FIFO
  // ==========================================================================
  logic [31:0] fifo_data;
  logic fifo_valid;
  logic fifo_ready;

  word_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) in_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_data(s_tdata),
    .in_valid(s_tvalid),
    .in_ready(s_tready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready)
  );

  // ==========================================================================
  // Request framer
  // ==========================================================================
  frame_state_t state_reg;
  logic [1:0] hidx_reg;
  logic [9:0] pidx_reg;
  logic [31:0] cur_block_reg;
  logic drive_reg;
  logic [7:0] tag_reg;
  logic out_valid_reg;
  logic [31:0] out_data_reg;
  logic out_last_reg;
  logic out_drive_reg;
  logic out_taken;
  logic can_load;
  logic hdr_load;
  logic [31:0] hdr_word;

  assign busy = state_reg != ST_IDLE;
  assign out_taken = out_valid_reg && (out_drive_reg ? m1_tready : m0_tready);
  assign can_load = !out_valid_reg || out_taken;
  assign hdr_load = state_reg == ST_HDR && can_load;
  assign fifo_ready = state_reg == ST_PAY && can_load;
  assign blk_end = fifo_ready && fifo_valid && pidx_reg == PAY_LAST;
  assign m_tdata = out_data_reg;
  assign m_tlast = out_last_reg;
  assign m0_tvalid = out_valid_reg && !out_drive_reg;
  assign m1_tvalid = out_valid_reg && out_drive_reg;

  always_comb begin
    unique case (hidx_reg)
      2'h0: hdr_word = {3'h0, drive_reg, stream_reg, cur_block_reg[ADDR_FIELD_W-1:0]};
      2'h1: hdr_word = '0;
      2'h2: hdr_word = {1'b0, 11'h0, stream_reg, REQ_WRITE, 1'b0, BLOCK_CNT};
      2'h3: hdr_word = {24'h0, tag_reg};
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      hidx_reg <= '0;
      pidx_reg <= '0;
      cur_block_reg <= '0;
      drive_reg <= 1'b0;
      tag_reg <= '0;
      written_reg <= '0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (start_pulse && num_blocks_reg != '0) begin
            state_reg <= ST_HDR;
            cur_block_reg <= start_block_reg;
            written_reg <= '0;
            drive_reg <= 1'b0;
            hidx_reg <= '0;
          end
        end
        ST_HDR: begin
          if (hdr_load) begin
            hidx_reg <= hidx_reg + 1'b1;
            if (hidx_reg == REQ_HDR_LAST) begin
              state_reg <= ST_PAY;
              pidx_reg <= '0;
            end
          end
        end
        ST_PAY: begin
          if (fifo_ready && fifo_valid) begin
            pidx_reg <= pidx_reg + 1'b1;
          end
          if (blk_end) begin
            drive_reg <= !drive_reg;
            cur_block_reg <= cur_block_reg + 1'b1;
            tag_reg <= tag_reg + 1'b1;
            written_reg <= written_reg + 1'b1;
            state_reg <= (written_reg + 1'b1 == num_blocks_reg) ? ST_IDLE : ST_HDR;
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_valid_reg <= 1'b0;
      out_data_reg <= '0;
      out_last_reg <= 1'b0;
      out_drive_reg <= 1'b0;
    end else if (hdr_load) begin
      out_valid_reg <= 1'b1;
      out_data_reg <= hdr_word;
      out_last_reg <= 1'b0;
      out_drive_reg <= drive_reg;
    end else if (fifo_ready && fifo_valid) begin
      out_valid_reg <= 1'b1;
      out_data_reg <= fifo_data;
      out_last_reg <= pidx_reg == PAY_LAST;
    end else if (out_taken) begin
      out_valid_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Reply decoder and read-back stream
  // ==========================================================================
  logic [1:0] ridx_reg;
  logic [31:0] rw0_reg;
  logic [31:0] rw1_reg;
  logic rpl_ok_reg;
  logic r_take;
  logic rd_valid_reg;
  logic [31:0] rd_data_reg;
  logic rd_last_reg;

  assign r_tready = !rd_valid_reg || rd_tready;
  assign r_take = r_tvalid && r_tready;
  assign rpl_done = r_take && ridx_reg == RPL_HDR_LAST && r_tdata[REPLY_FLAG];
  assign rpl_bad = rpl_done && rw0_reg[RE_LSB +: 4] != 4'h0;
  assign rd_tdata = rd_data_reg;
  assign rd_tvalid = rd_valid_reg;
  assign rd_tlast = rd_last_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ridx_reg <= '0;
      rw0_reg <= '0;
      rw1_reg <= '0;
      rpl_ok_reg <= 1'b0;
    end else if (r_take) begin
      if (ridx_reg == 2'h0) begin
        rw0_reg <= r_tdata;
      end
      if (ridx_reg == 2'h1) begin
        rw1_reg <= r_tdata;
      end
      if (ridx_reg == RPL_HDR_LAST) begin
        rpl_ok_reg <= r_tdata[REPLY_FLAG];
      end
      if (r_tlast) begin
        ridx_reg <= '0;
      end else if (ridx_reg != RPL_PAYLOAD) begin
        ridx_reg <= ridx_reg + 1'b1;
      end
    end
  end

  // Only the defined fields are kept; all other header bits are ignored.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rpl_bytes_reg <= '0;
      rpl_err_reg <= '0;
      rpl_stat_reg <= '0;
      rpl_drv_reg <= '0;
      rpl_tag_reg <= '0;
    end else if (rpl_done) begin
      rpl_bytes_reg <= rw0_reg[RB_LSB +: 12];
      rpl_err_reg <= rw0_reg[RE_LSB +: 4];
      rpl_stat_reg <= rw1_reg[RU_LSB +: 4];
      rpl_drv_reg <= r_tdata[RN_LSB +: 4];
      rpl_tag_reg <= r_tdata[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_valid_reg <= 1'b0;
      rd_data_reg <= '0;
      rd_last_reg <= 1'b0;
    end else if (r_take && ridx_reg == RPL_PAYLOAD && rpl_ok_reg) begin
      rd_valid_reg <= 1'b1;
      rd_data_reg <= r_tdata;
      rd_last_reg <= r_tlast;
    end else if (rd_tready) begin
      rd_valid_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  word_one_zero_a: assert property (hdr_load && hidx_reg == 2'h1 |=> out_data_reg == 32'h0)
    else $error("request word 1 not zero");
  request_flag_a: assert property (hdr_load && hidx_reg == 2'h2 |=> !out_data_reg[REPLY_FLAG] && out_data_reg[CNT_W-1:0] == BLOCK_CNT)
    else $error("request word 2 bad flag or count");
  drive_toggle_a: assert property (blk_end |=> drive_reg != $past(drive_reg))
    else $error("drive did not alternate");
  route_nibble_a: assert property (hdr_load && hidx_reg == 2'h0 |=> out_data_reg[31:28] == {3'h0, out_drive_reg} && (m1_tvalid == out_drive_reg))
    else $error("route nibble does not match path");
  block_tlast_a: assert property (blk_end |=> out_last_reg && out_valid_reg ##1 !out_last_reg || !out_valid_reg || $stable(out_data_reg))
    else $error("tlast not on block end");
  exact_range_a: assert property ($rose(done_reg) |-> written_reg == num_blocks_reg && state_reg == ST_IDLE)
    else $error("written range differs from count");
  payload_follows_a: assert property (hdr_load && hidx_reg == 2'h3 |=> state_reg == ST_PAY && pidx_reg == 10'h0)
    else $error("payload does not follow header");
  reply_gate_a: assert property (r_take && ridx_reg == 2'h2 && !r_tdata[31] |=> !rpl_ok_reg ##1 !$rose(rd_valid_reg))
    else $error("non-reply forwarded");
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");

  cover_block_c: cover property (blk_end ##[1:20] hdr_load);
  cover_done_c: cover property ($rose(done_reg));
  cover_reply_c: cover property (rpl_done ##[1:10] rd_tvalid && rd_tlast);
endmodule : storage_packet_header_format

// ---- sim/drive_partner.sv ----
// Far-side model: request path sink with stalls and a reply packet source.
// Assumes the bench drives hold and calls send right after a clock edge.
`timescale 1ns/1ps
module drive_partner (
  input wire logic aclk, // Clock.
  input wire logic hold, // Stall both request paths.
  output logic m0_tready, // Drive 0 path ready.
  output logic m1_tready, // Drive 1 path ready.
  output logic [31:0] r_tdata, // Reply word.
  output logic r_tvalid, // Reply word valid.
  output logic r_tlast, // Last reply word.
  input wire logic r_tready // Reply word taken.
);
  initial begin
    {m0_tready, m1_tready, r_tvalid, r_tlast, r_tdata} = '0;
  end
  // ==========================================================================
  // Request sink
  // ==========================================================================
  always @(posedge aclk) begin
    m0_tready <= !hold && $urandom_range(3) != 0;
    m1_tready <= !hold && $urandom_range(3) != 0;
  end
  // ==========================================================================
  // Reply source
  // ==========================================================================
  task automatic send(input logic [3:0] dv, u, e, s, input logic [11:0] b, input logic [7:0] t,
                      input logic rp, input int n, input logic [31:0] p);
    logic [31:0] w;
    for (int i = 0; i < n + 3; i++) begin
      w = i == 0 ? {4'h0, b, e, 12'h0} : i == 1 ? {12'h0, s, u, 12'(n)} :
          i == 2 ? {rp, 11'h0, dv, 8'h0, t} : p + i;
      r_tdata <= w;
      r_tvalid <= 1'b1;
      r_tlast <= i == n + 2;
      do @(posedge aclk); while (r_tready !== 1'b1);
    end
    r_tvalid <= 1'b0;
    r_tlast <= 1'b0;
    // A released bus must not keep showing the last word.
    r_tdata <= ~w;
  endtask : send
endmodule : drive_partner

// ---- sim/tb.sv ----
// Self-checking bench for the dual-drive block framer.
// Assumes drive_partner stands on the request and reply streams.
`timescale 1ns/1ps
module tb;
  import storage_packet_pkg::*;
  logic aclk = 0, aresetn = 0, hold = 1;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, s_tdata = 0, m_tdata, rdata, r_tdata, rd_tdata, st, sb, x;
  logic [3:0] wstrb = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, s_tvalid = 0, rd_tready = 0;
  logic awready, wready, bvalid, arready, rvalid, s_tready, m_tlast, m0_tvalid, m0_tready;
  logic m1_tvalid, m1_tready, r_tvalid, r_tready, r_tlast, rd_tvalid, rd_tlast;
  logic [1:0] bresp, rresp;
  int fails = 0, n_compared = 0, cyc = 0;
  logic [33:0] rq[$];
  logic [32:0] dq[$];
  logic [31:0] pay[2048];
  always #5 aclk = ~aclk;
  storage_packet_header_format i_storage_packet_header_format (.*);
  drive_partner i_drive_partner (.*);
  // ==========================================================================
  // Checking and bus tasks
  // ==========================================================================
  task automatic cmp(input logic [35:0] g, e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  task automatic test_done;
    if (fails == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1;
    wvalid <= 1;
    do begin
      @(posedge aclk);
      if (awready && awvalid) awvalid <= 0;
      if (wready && wvalid) wvalid <= 0;
    end while (bvalid !== 1'b1);
    // A late bready makes the slave hold its response for one cycle.
    bready <= 1;
    @(posedge aclk);
    bready <= 0;
    cmp(bresp, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge aclk);
      if (arready && arvalid) arvalid <= 0;
    end while (rvalid !== 1'b1);
    rready <= 0;
    cmp({rresp, rdata}, {r, e});
  endtask : rd
  // ==========================================================================
  // Stream monitors and timeout
  // ==========================================================================
  always @(posedge aclk) begin
    cyc++;
    if (cyc > 20000) begin
      fails++;
      test_done;
    end
    rd_tready <= $urandom_range(2) != 0;
    if (aresetn && (m0_tvalid && m0_tready || m1_tvalid && m1_tready))
      cmp({m1_tvalid, m_tlast, m_tdata}, rq.size() ? rq.pop_front() : '1);
    if (aresetn && rd_tvalid && rd_tready)
      cmp({rd_tlast, rd_tdata}, dq.size() ? dq.pop_front() : '1);
  end
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    x = $urandom(13083);
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(REG_START, START_RESET, RESP_OKAY);
    rd(REG_COUNT, COUNT_RESET, RESP_OKAY);
    rd(REG_STATUS, 0, RESP_OKAY);
    rd(REG_CTRL, 0, RESP_OKAY);
    rd(8'h40, 0, RESP_SLVERR);
    wr(8'h40, 1, RESP_SLVERR);
    st = $urandom_range(15);
    sb = $urandom & 32'hfffffe;
    for (int k = 0; k < 2; k++) begin
      rq.push_back({k[0], 1'b0, 3'b0, k[0], st[3:0], 24'(sb + k)});
      rq.push_back({k[0], 33'h0});
      rq.push_back({k[0], 13'h0, st[3:0], REQ_WRITE, 1'b0, BLOCK_CNT});
      rq.push_back({k[0], 25'h0, 8'(k)});
      for (int i = 0; i < BLOCK_WORDS; i++) begin
        pay[k * BLOCK_WORDS + i] = $urandom;
        rq.push_back({k[0], i == BLOCK_WORDS - 1, pay[k * BLOCK_WORDS + i]});
      end
    end
    wr(REG_STREAM, st, RESP_OKAY);
    wr(REG_START, sb, RESP_OKAY);
    wr(REG_COUNT, 2, RESP_OKAY);
    rd(REG_COUNT, 2, RESP_OKAY);
    fork
      begin
        for (int i = 0; i < 2048; i++) begin
          s_tdata <= pay[i];
          s_tvalid <= 1;
          do @(posedge aclk); while (s_tready !== 1'b1);
        end
        s_tvalid <= 0;
      end
    join_none
    repeat (40) @(posedge aclk);
    cmp(s_tready, 0);
    wr(REG_CTRL, 1, RESP_OKAY);
    rd(REG_STATUS, 1, RESP_OKAY);
    wr(REG_COUNT, 5, RESP_OKAY);
    hold <= 0;
    while (rq.size() != 0) @(posedge aclk);
    repeat (3) @(posedge aclk);
    rd(REG_WRITTEN, 2, RESP_OKAY);
    rd(REG_STATUS, 2, RESP_OKAY);
    rd(REG_COUNT, 2, RESP_OKAY);
    x = $urandom;
    dq.push_back({1'b0, x + 3});
    dq.push_back({1'b1, x + 4});
    i_drive_partner.send(x[3:0], x[7:4], x[11:8] | 4'h1, st[3:0], x[23:12], x[31:24], 1'b1, 2, x);
    while (dq.size() != 0) @(posedge aclk);
    rd(REG_REPLY, {x[3:0], x[7:4], x[11:8] | 4'h1, x[23:12], x[31:24]}, RESP_OKAY);
    rd(REG_STATUS, 6, RESP_OKAY);
    wr(REG_STATUS, 4, RESP_OKAY);
    rd(REG_STATUS, 2, RESP_OKAY);
    i_drive_partner.send(x[3:0], x[7:4], 4'h0, st[3:0], x[23:12], x[31:24], 1'b0, 2, x);
    repeat (10) @(posedge aclk);
    cmp(rq.size() + dq.size(), 0);
    test_done;
  end
endmodule : tb
